/* File: verilog/serial_port_map.vh */
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
// oversampling per async bit
`define OVERSAMPLE 16
// count-source prescale when countSource is one
`define PRESCALE_M4 4
`define PRESCALE_M1 1
`define DATA_BITS 8
`define BIT_COUNT_W 4
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define IDLE_LEVEL 1'b1
`endif

/* File: verilog/tx_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire ref_clk,
   input wire reset,
   input wire flush,
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output wire inReady,
   output reg [WIDTH-1:0] outData,
   output wire outValid,
   input wire outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_q;
   reg [AW:0] rdPtr_q;
   reg [AW:0] count_q;
   wire doWrite = inValid & inReady;
   wire doRead = outValid & outReady;
   assign inReady = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   // read word is registered; a write into an emptying buffer is passed straight through
   wire [AW:0] rdNext = rdPtr_q + {{AW{1'b0}}, doRead};
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         outData <= {WIDTH{1'b0}};
      end else if (flush) begin
         outData <= outData;
      end else if (doWrite & (wrPtr_q == rdNext)) begin
         outData <= inData;
      end else begin
         outData <= mem[rdNext[AW-1:0]];
      end
   end
   always @(posedge ref_clk) begin
      if (doWrite) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wrPtr_q <= {(AW+1){1'b0}};
         rdPtr_q <= {(AW+1){1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else if (flush) begin
         wrPtr_q <= {(AW+1){1'b0}};
         rdPtr_q <= {(AW+1){1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (doWrite) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (doRead) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         if (doWrite & ~doRead) begin
            count_q <= count_q + 1'b1;
         end else if (doRead & ~doWrite) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // tx_fifo
`default_nettype wire

/* File: verilog/serial_port_enable_control.v */
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module serial_port_enable_control (
   input wire ref_clk,
   input wire reset,
   input wire portEnable,
   input wire txEnable,
   input wire rxEnable,
   input wire syncMode,
   input wire extClock,
   input wire readyOutEnable,
   input wire countSource,
   input wire txIntOnShiftDone,
   input wire [7:0] baudDivider,
   input wire [7:0] txData,
   input wire txWrite,
   output wire txWriteReady,
   output reg [7:0] rxData,
   output reg rxFull,
   input wire rxRead,
   output reg txBufferEmpty,
   output reg txShiftComplete,
   output reg txIntRequest,
   input wire txIntClear,
   output reg txdOut,
   output reg shiftClockOut,
   output reg shiftClockOutEn,
   output reg readyOutN,
   input wire shiftClockIn,
   input wire rxdIn
);
   localparam ST_IDLE = 2'b00;
   localparam ST_LOAD = 2'b01;
   localparam ST_SHIFT = 2'b10;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [1:0] sclkSync_q;
   reg [1:0] rxdSync_q;
   reg sclkPrev_q;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclkSync_q <= 2'b11;
         rxdSync_q <= 2'b11;
         sclkPrev_q <= 1'b1;
      end else begin
         sclkSync_q <= {sclkSync_q[0], shiftClockIn};
         rxdSync_q <= {rxdSync_q[0], rxdIn};
         sclkPrev_q <= sclkSync_q[1];
      end
   end
   wire sclk = sclkSync_q[1];
   wire rxd = rxdSync_q[1];

   // ----------------------------------------
   // baud divider
   // ----------------------------------------
   // divider period less one: (div + 1) * m - 1, m is 4 or 1
   function [9:0] tickLast;
      input [7:0] div;
      input cs;
      begin
         tickLast = cs ? {div, 2'b11} : {2'b00, div};
      end
   endfunction
   wire txRun_d;
   reg [9:0] divCnt_q;
   reg [3:0] osCnt_q;
   wire tick = (divCnt_q == 10'h000);
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         divCnt_q <= 10'h000;
         osCnt_q <= 4'h0;
      end else if (tick) begin
         divCnt_q <= tickLast(baudDivider, countSource);
         osCnt_q <= osCnt_q + 4'h1;
      end else begin
         divCnt_q <= divCnt_q - 10'h001;
      end
   end
   // half bit period strobes: rising and falling shift clock edges
   wire halfStrobe = tick & (osCnt_q[2:0] == 3'h7);
   wire intFall = halfStrobe & ~osCnt_q[3];
   wire intRise = halfStrobe & osCnt_q[3];
   wire extFall = sclkPrev_q & ~sclk;
   wire extRise = ~sclkPrev_q & sclk;
   wire asyncBit = tick & (osCnt_q == 4'hf);
   wire shiftEdge = syncMode ? (extClock ? extFall : intFall) : asyncBit;
   wire sampleEdge = syncMode ? (extClock ? extRise : intRise) : 1'b0;

   // ----------------------------------------
   // transmit buffer and shifter
   // ----------------------------------------
   wire [7:0] fifoData;
   wire fifoValid;
   reg fifoPop;
   wire circuitReset = ~txEnable & ~rxEnable;
   // sync run adds receive enable, but fifoPop also needs txEnable: no frame or clock starts while only receiving
   assign txRun_d = syncMode ? (txEnable | rxEnable) : txEnable;
   tx_fifo #(.WIDTH(`DATA_BITS), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) txBuf (
      .ref_clk(ref_clk),
      .reset(reset),
      .flush(circuitReset),
      .inData(txData),
      .inValid(txWrite),
      .inReady(txWriteReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoPop)
   );
   reg [1:0] state_q;
   reg [9:0] shiftReg_q;
   reg [3:0] bitCnt_q;
   reg txEnablePrev_q;
   reg txLineBit_q;
   wire txRise = txEnable & ~txEnablePrev_q;
   reg halfSeen_q;
   // half a shift clock must pass before the first shift edge, except with an external sync clock, which shifts at its first edge
   wire halfMark = syncMode ? (sampleEdge | extClock) : intFall;
   wire [3:0] lastCnt = syncMode ? 4'h8 : 4'ha;
   // sync frames end at the sampling edge of the last bit
   wire endEdge = syncMode ? sampleEdge : shiftEdge;
   wire shiftDone = (state_q == ST_SHIFT) & (bitCnt_q == lastCnt) & endEdge;
   always @* begin
      fifoPop = (state_q == ST_IDLE) & txRun_d & fifoValid & txEnable;
   end
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         shiftReg_q <= 10'h3ff;
         bitCnt_q <= 4'h0;
         txEnablePrev_q <= 1'b0;
         halfSeen_q <= 1'b0;
         txLineBit_q <= `IDLE_LEVEL;
         txBufferEmpty <= 1'b0;
         txShiftComplete <= 1'b0;
         txIntRequest <= 1'b0;
      end else begin
         txEnablePrev_q <= txEnable;
         if (circuitReset) begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            txLineBit_q <= `IDLE_LEVEL;
         end else begin
            // port enable is not looked at: shifting goes on internally
            case (state_q)
               ST_IDLE: begin
                  if (fifoPop) begin
                     shiftReg_q <= syncMode ? {2'b11, fifoData} : {1'b1, fifoData, 1'b0};
                     halfSeen_q <= halfMark;
                     state_q <= ST_LOAD;
                  end
               end
               ST_LOAD: begin
                  // flag falls at the first shift edge after a half clock: 0.5 to 1.5 clocks; an external sync clock needs no half clock
                  if (shiftEdge & halfSeen_q) begin
                     txShiftComplete <= 1'b0;
                     txLineBit_q <= shiftReg_q[0];
                     shiftReg_q <= {1'b1, shiftReg_q[9:1]};
                     bitCnt_q <= 4'h1;
                     state_q <= ST_SHIFT;
                  end else if (halfMark) begin
                     halfSeen_q <= 1'b1;
                  end
               end
               ST_SHIFT: begin
                  if (bitCnt_q == lastCnt) begin
                     if (endEdge) begin
                        txLineBit_q <= `IDLE_LEVEL;
                        state_q <= ST_IDLE;
                        txShiftComplete <= ~fifoValid;
                        if (~fifoValid & txIntOnShiftDone) begin
                           txIntRequest <= 1'b1;
                        end
                     end
                  end else if (shiftEdge) begin
                     txLineBit_q <= shiftReg_q[0];
                     shiftReg_q <= {1'b1, shiftReg_q[9:1]};
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
         if (txRise) begin
            txBufferEmpty <= 1'b1;
            txShiftComplete <= 1'b1;
         end else begin
            txBufferEmpty <= ~fifoValid | (fifoPop & ~fifoValid);
         end
         // set wins over a clearing in the same cycle
         if (txRise | (fifoPop & ~txIntOnShiftDone)) begin
            txIntRequest <= 1'b1;
         end else if (txIntClear & ~shiftDone) begin
            txIntRequest <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // receiver and pins
   // ----------------------------------------
   wire rxActive = syncMode ? (rxEnable & portEnable) : rxEnable;
   reg [7:0] rxShift_q;
   reg [3:0] rxCnt_q;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rxShift_q <= 8'h00;
         rxCnt_q <= 4'h0;
         rxData <= 8'h00;
         rxFull <= 1'b0;
      end else begin
         if (~rxActive | circuitReset) begin
            rxCnt_q <= 4'h0;
         end else if (syncMode & sampleEdge & state_q == ST_SHIFT) begin
            rxShift_q <= {rxd, rxShift_q[7:1]};
            rxCnt_q <= (rxCnt_q == 4'h7) ? 4'h0 : rxCnt_q + 4'h1;
         end else if (~syncMode & asyncBit) begin
            if (rxCnt_q == 4'h0) begin
               rxCnt_q <= rxd ? 4'h0 : 4'h1;
            end else if (rxCnt_q == 4'h9) begin
               rxCnt_q <= 4'h0;
            end else begin
               rxShift_q <= {rxd, rxShift_q[7:1]};
               rxCnt_q <= rxCnt_q + 4'h1;
            end
         end
         if ((syncMode & sampleEdge & state_q == ST_SHIFT & rxCnt_q == 4'h7 & rxActive) |
             (~syncMode & asyncBit & rxCnt_q == 4'h8 & rxActive)) begin
            rxData <= {rxd, rxShift_q[7:1]};
            rxFull <= 1'b1;
         end else if (rxRead) begin
            rxFull <= 1'b0;
         end
      end
   end
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         txdOut <= `IDLE_LEVEL;
         shiftClockOut <= 1'b1;
         shiftClockOutEn <= 1'b0;
         readyOutN <= 1'b1;
      end else begin
         // pins are general I/O when disabled; re-enable exposes the shifter
         txdOut <= portEnable ? txLineBit_q : `IDLE_LEVEL;
         // low from the shifting edge to the sampling edge of each bit
         shiftClockOut <= ~(state_q == ST_SHIFT & osCnt_q[3]);
         shiftClockOutEn <= portEnable & syncMode & ~extClock;
         readyOutN <= ~(portEnable & syncMode & rxEnable & readyOutEnable & txEnable);
      end
   end
endmodule // serial_port_enable_control
`default_nettype wire

/* File: dv/serial_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_port_assertions (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic portEnable,
   input wire logic txEnable,
   input wire logic rxEnable,
   input wire logic syncMode,
   input wire logic extClock,
   input wire logic readyOutEnable,
   input wire logic countSource,
   input wire logic [7:0] baudDivider,
   input wire logic txWrite,
   input wire logic txWriteReady,
   input wire logic rxFull,
   input wire logic txBufferEmpty,
   input wire logic txShiftComplete,
   input wire logic txIntRequest,
   input wire logic txdOut,
   input wire logic shiftClockOutEn,
   input wire logic readyOutN
);
   logic armed_q;
   logic [15:0] waitCnt_q;
   logic [15:0] halfBit;
   // half of one async bit, in clock cycles
   assign halfBit = ({8'h00, baudDivider} + 16'h0001) * (countSource ? 16'h0020 : 16'h0008);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         armed_q <= 1'b0;
         waitCnt_q <= 16'h0000;
      end else if (txWrite && txWriteReady && !armed_q) begin
         armed_q <= txEnable && txShiftComplete && txBufferEmpty && !syncMode;
         waitCnt_q <= 16'h0000;
      end else begin
         armed_q <= armed_q && txShiftComplete && (txEnable || rxEnable) && !syncMode;
         waitCnt_q <= waitCnt_q + 16'h0001;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_txen_flags: assert property ($rose(txEnable) |-> ##[1:2] (txBufferEmpty && txShiftComplete))
      else $error("flags not raised by transmit enable");
   chk_txen_request: assert property ($rose(txEnable) |-> ##[1:2] txIntRequest)
      else $error("no transmit request on enable");
   chk_port_idle: assert property (!portEnable && $past(!portEnable) |-> txdOut)
      else $error("serial out driven while port off");
   chk_clock_pin: assert property (shiftClockOutEn |-> $past(portEnable && syncMode && !extClock))
      else $error("shift clock driven without cause");
   chk_ready_gate: assert property (!readyOutN |-> $past(rxEnable && readyOutEnable && txEnable))
      else $error("ready out low without all enables");
   chk_both_off: assert property ((!txEnable && !rxEnable)[*3] |-> txdOut && txWriteReady)
      else $error("circuits not reset with both enables off");
   chk_rx_stop: assert property ((!rxEnable || (syncMode && !portEnable))[*2] |-> !$rose(rxFull))
      else $error("byte received while reception off");
   chk_shift_fall: assert property (armed_q && $fell(txShiftComplete) |->
      waitCnt_q >= halfBit - 16'h0001 && waitCnt_q <= halfBit * 16'h0003 + 16'h0001)
      else $error("shift complete fell outside window");
   chk_shift_start: assert property (armed_q && !portEnable |-> ##[1:1000] !txShiftComplete)
      else $error("disabled port did not start shifting");
   cover property (armed_q && $fell(txShiftComplete));
   cover property ($rose(rxFull) && syncMode);
   cover property (shiftClockOutEn);
endmodule // serial_port_assertions
bind serial_port_enable_control serial_port_assertions serial_port_assertions_i (.ref_clk, .reset, .portEnable,
   .txEnable, .rxEnable, .syncMode, .extClock, .readyOutEnable, .countSource, .baudDivider, .txWrite, .txWriteReady,
   .rxFull, .txBufferEmpty, .txShiftComplete, .txIntRequest, .txdOut, .shiftClockOutEn, .readyOutN);
`default_nettype wire

/* File: dv/serial_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
   input wire logic ref_clk,
   output var logic rxdLine,
   output var logic shiftClock
);
   initial begin
      rxdLine = 1'b1;
      shiftClock = 1'b1;
   end
   // one async frame, lsb first; line rests at its pull-up level
   task automatic sendAsync(input logic [7:0] b, input int bitCyc);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxdLine <= f[i];
         repeat (bitCyc) @(posedge ref_clk);
      end
   endtask
   // eight clocks; clock rests high so the host writes at the falling edge
   task automatic clockSync(input logic [7:0] b, input int halfCyc);
      for (int i = 0; i < 8; i++) begin
         shiftClock <= 1'b0;
         rxdLine <= b[i];
         repeat (halfCyc) @(posedge ref_clk);
         shiftClock <= 1'b1;
         repeat (halfCyc) @(posedge ref_clk);
      end
      rxdLine <= ~b[7];
   endtask
endmodule // serial_partner
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0, reset = 1'b1, portEnable = 1'b0, txEnable = 1'b0, rxEnable = 1'b0, syncMode = 1'b0;
   logic extClock = 1'b0, readyOutEnable = 1'b0, countSource = 1'b0, txIntOnShiftDone = 1'b0, txWrite = 1'b0;
   logic rxRead = 1'b0, txIntClear = 1'b0;
   logic [7:0] baudDivider = 8'h01, txData = 8'h00, rxData;
   logic txWriteReady, rxFull, txBufferEmpty, txShiftComplete, txIntRequest, txdOut;
   logic shiftClockOut, shiftClockOutEn, readyOutN, shiftClockIn, rxdIn;
   logic [9:0] frame;
   int badCount = 0, nChecks = 0, n;
   always #20 ref_clk = ~ref_clk;
   serial_port_enable_control serial_port_enable_control_i (.ref_clk, .reset, .portEnable, .txEnable, .rxEnable,
      .syncMode, .extClock, .readyOutEnable, .countSource, .txIntOnShiftDone, .baudDivider, .txData, .txWrite,
      .txWriteReady, .rxData, .rxFull, .rxRead, .txBufferEmpty, .txShiftComplete, .txIntRequest, .txIntClear,
      .txdOut, .shiftClockOut, .shiftClockOutEn, .readyOutN, .shiftClockIn, .rxdIn);
   serial_partner serial_partner_i (.ref_clk, .rxdLine(rxdIn), .shiftClock(shiftClockIn));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic push(input logic [7:0] b);
      txData <= b;
      txWrite <= 1'b1;
      @(posedge ref_clk);
      txWrite <= 1'b0;
   endtask
   task automatic idle;
      for (int i = 0; i < 9000 && !(txShiftComplete === 1'b1 && txBufferEmpty === 1'b1); i++) @(posedge ref_clk);
   endtask
   task automatic waitRx;
      for (int i = 0; i < 2000 && rxFull !== 1'b1; i++) @(negedge ref_clk);
   endtask
   task automatic grab(input int per, output logic [9:0] f);
      for (int i = 0; i < 9000 && txdOut !== 1'b0; i++) @(posedge ref_clk);
      repeat (per / 2) @(posedge ref_clk);
      for (int i = 0; i < 10; i++) begin
         f[i] = txdOut;
         repeat (per) @(posedge ref_clk);
      end
   endtask
   initial begin
      #2400000;
      badCount++;
      end_of_test;
   end
   // ---------------------------------------
   // tests
   // ---------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      check("reset state", {txdOut, shiftClockOut, shiftClockOutEn, readyOutN, txBufferEmpty, txShiftComplete, rxFull},
         7'h68);
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         countSource <= k[0];
         txIntOnShiftDone <= k[0];
         portEnable <= 1'b1;
         txEnable <= 1'b1;
         repeat (3) @(negedge ref_clk);
         check("flags on enable", {txBufferEmpty, txShiftComplete, txIntRequest}, 3'h7);
         @(posedge ref_clk);
         txIntClear <= 1'b1;
         @(posedge ref_clk);
         txIntClear <= 1'b0;
         push(8'hA5 ^ {7'h00, k[0]});
         grab(32 << (2 * k), frame);
         check("async frame", frame, {1'b1, 8'hA5 ^ {7'h00, k[0]}, 1'b0});
         idle;
         txEnable <= 1'b0;
         portEnable <= 1'b0;
      end
      @(posedge ref_clk);
      countSource <= 1'b0;
      txEnable <= 1'b1;
      repeat (2) @(posedge ref_clk);
      push(8'h00);
      repeat (60) @(negedge ref_clk);
      check("shift started", txShiftComplete, 1'b0);
      n = 0;
      repeat (360) @(negedge ref_clk) if (txdOut !== 1'b1) n++;
      check("serial out while off", n, 0);
      @(posedge ref_clk);
      push(8'h00);
      repeat (100) @(posedge ref_clk);
      portEnable <= 1'b1;
      n = 0;
      repeat (100) @(negedge ref_clk) if (txdOut === 1'b0) n++;
      check("partial data out", n != 0, 1'b1);
      @(posedge ref_clk);
      idle;
      txWrite <= 1'b1;
      n = 0;
      repeat (12) begin
         @(negedge ref_clk);
         if (txWriteReady === 1'b1) n++;
         @(posedge ref_clk);
      end
      txWrite <= 1'b0;
      txEnable <= 1'b0;
      check("bytes taken", n, 9);
      repeat (3) @(negedge ref_clk);
      check("buffer flushed", txWriteReady, 1'b1);
      @(posedge ref_clk);
      rxEnable <= 1'b1;
      @(posedge ref_clk);
      serial_partner_i.sendAsync(8'h3C, 32);
      waitRx;
      check("async byte", rxData, 8'h3C);
      @(posedge ref_clk);
      rxRead <= 1'b1;
      @(posedge ref_clk);
      rxRead <= 1'b0;
      rxEnable <= 1'b0;
      serial_partner_i.sendAsync(8'hC3, 32);
      repeat (40) @(negedge ref_clk);
      check("rx off", rxFull, 1'b0);
      @(posedge ref_clk);
      syncMode <= 1'b1;
      extClock <= 1'b1;
      readyOutEnable <= 1'b1;
      txEnable <= 1'b1;
      rxEnable <= 1'b1;
      repeat (4) @(posedge ref_clk);
      push(8'h5A);
      repeat (2) @(negedge ref_clk);
      check("ready out", readyOutN, 1'b0);
      @(posedge ref_clk);
      serial_partner_i.clockSync(8'h96, 8);
      waitRx;
      check("sync byte", rxData, 8'h96);
      check("sync tx done", txShiftComplete, 1'b1);
      @(posedge ref_clk);
      rxRead <= 1'b1;
      portEnable <= 1'b0;
      @(posedge ref_clk);
      rxRead <= 1'b0;
      serial_partner_i.clockSync(8'h69, 8);
      repeat (20) @(negedge ref_clk);
      check("sync rx off", rxFull, 1'b0);
      @(posedge ref_clk);
      txEnable <= 1'b0;
      rxEnable <= 1'b0;
      @(posedge ref_clk);
      extClock <= 1'b0;
      portEnable <= 1'b1;
      txEnable <= 1'b1;
      repeat (3) @(posedge ref_clk);
      push(8'hFF);
      n = 0;
      repeat (400) @(negedge ref_clk) if (shiftClockOutEn === 1'b1 && shiftClockOut === 1'b0) n++;
      check("internal shift clock", n, 128);
      end_of_test;
   end
endmodule // testbench
`default_nettype wire
